//--- logic/dsw_defs.svh
// Purpose: named constants of the drive status word block
// Assumes: included by the package and by every design module
// Notes: definitions only
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH

`define DSW_WORD_W 16
`define DSW_NWORDS 6
`define DSW_SEL_W 3
`define DSW_IDX_W 3

// status word bit positions
`define DSW_SB_RDY_START 0
`define DSW_SB_READY 1
`define DSW_SB_OPER 2
`define DSW_SB_FAULT 3
`define DSW_SB_NO_COAST 4
`define DSW_SB_NO_FAST 5
`define DSW_SB_LOCKOUT 6
`define DSW_SB_WARN 7
`define DSW_SB_SPD_TOL 8
`define DSW_SB_MASTER_REQ 9
`define DSW_SB_SPD_CMP 10
`define DSW_SB_LIMIT_N 11
`define DSW_SB_BRAKE 12
`define DSW_SB_MOT_TEMP_N 13
`define DSW_SB_CW 14
`define DSW_SB_B15 15

// control word bit positions
`define DSW_CB_ON 0
`define DSW_CB_NO_COAST 1
`define DSW_CB_NO_FAST 2
`define DSW_CB_ENABLE_OP 3
`define DSW_CB_FAULT_ACK 7
`define DSW_CB_PLC_CTRL 10
`define DSW_CB_CDS0 15

// telegram codes
`define DSW_TEL_STD1 16'h0001
`define DSW_TEL_STD20 16'h0014
`define DSW_TEL_352 16'h0160
`define DSW_TEL_353 16'h0161
`define DSW_TEL_354 16'h0162
`define DSW_TEL_FREE 16'h03e7

// parameter write targets
`define DSW_PAR_TEL 2'h0
`define DSW_PAR_EXT 2'h1
`define DSW_PAR_SEND 2'h2

// send word counts
`define DSW_CNT_2 3'h2
`define DSW_CNT_6 3'h6

// reset values
`define DSW_STATUS_RESET 16'h0000
`define DSW_CTRL_RESET 16'h0000
// send word k takes source k until free configuration remaps it
`define DSW_SEL_RESET 18'h2c688

`endif

//--- logic/dsw_pkg.sv
// Purpose: types shared by the drive status word block
// Assumes: constants come from dsw_defs.svh
// Notes: one packed struct holds all state of each module
package dsw_pkg;
`include "dsw_defs.svh"

    typedef logic [`DSW_WORD_W-1:0] dsw_word_t;
    typedef logic [`DSW_SEL_W-1:0] dsw_sel_t;
    typedef logic [`DSW_NWORDS*`DSW_WORD_W-1:0] dsw_words_t;
    typedef logic [`DSW_NWORDS*`DSW_SEL_W-1:0] dsw_sels_t;

    typedef enum logic [5:0] {
        DSW_ST_INIT = 6'b000001,
        DSW_ST_LOCKOUT = 6'b000010,
        DSW_ST_RDY_START = 6'b000100,
        DSW_ST_READY = 6'b001000,
        DSW_ST_OPER = 6'b010000,
        DSW_ST_FAULT = 6'b100000
    } dsw_state_e;

    typedef struct packed {
        dsw_word_t tel;
        dsw_word_t ext;
        dsw_sels_t sel;
        logic err;
    } dsw_cfg_s;

    typedef struct packed {
        dsw_state_e state;
        dsw_word_t cw;
        logic fault_lat;
        logic ack_pulse;
        logic spd_pos;
        logic prev_valid;
        dsw_word_t status;
        dsw_words_t rx;
        dsw_words_t tx;
        dsw_word_t tel;
        logic parameter_channel_words;
        logic [2:0] tx_count;
    } dsw_core_s;
endpackage

//--- logic/dsw_telegram_cfg.sv
// Purpose: telegram selection and send word selection table
// Assumes: parameter writes arrive as single-cycle strobes
// Notes: mapping can only change while free configuration is selected
`include "dsw_defs.svh"
module dsw_telegram_cfg (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_par_wr,
    input wire [1:0] i_par_id,
    input wire [`DSW_IDX_W-1:0] i_par_idx,
    input dsw_pkg::dsw_word_t i_par_data,
    output dsw_pkg::dsw_word_t o_eff_telegram,
    output logic o_free,
    output logic [2:0] o_tx_count,
    output logic o_pkw,
    output dsw_pkg::dsw_sels_t o_send_sel,
    output logic o_par_err
);
    import dsw_pkg::*;

    dsw_cfg_s q;
    dsw_cfg_s next_q;

    function automatic logic known_code(input dsw_word_t c);
        known_code = (c == `DSW_TEL_STD1) || (c == `DSW_TEL_STD20) ||
            (c == `DSW_TEL_352) || (c == `DSW_TEL_353) ||
            (c == `DSW_TEL_354) || (c == `DSW_TEL_FREE);
    endfunction

    always_comb begin
        next_q = q;
        next_q.err = 1'b0;
        if (i_par_wr) begin
            if (i_par_id == `DSW_PAR_TEL) begin
                if (known_code(i_par_data)) begin
                    next_q.tel = i_par_data;
                    // a fixed telegram also seeds the extension base
                    if (i_par_data != `DSW_TEL_FREE) begin
                        next_q.ext = i_par_data;
                        next_q.sel = `DSW_SEL_RESET;
                    end
                end else begin
                    next_q.err = 1'b1;
                end
            end else if (i_par_id == `DSW_PAR_EXT) begin
                if (q.tel == `DSW_TEL_FREE && known_code(i_par_data)) begin
                    next_q.ext = i_par_data;
                end else begin
                    next_q.err = 1'b1;
                end
            end else if (i_par_id == `DSW_PAR_SEND) begin
                if (q.tel == `DSW_TEL_FREE &&
                    i_par_idx < `DSW_IDX_W'(`DSW_NWORDS)) begin
                    next_q.sel[i_par_idx*`DSW_SEL_W +: `DSW_SEL_W] =
                        i_par_data[`DSW_SEL_W-1:0];
                end else begin
                    next_q.err = 1'b1;
                end
            end else begin
                next_q.err = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q.tel <= `DSW_TEL_STD1;
            q.ext <= `DSW_TEL_STD1;
            q.sel <= `DSW_SEL_RESET;
            q.err <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    assign o_free = (q.tel == `DSW_TEL_FREE);
    assign o_eff_telegram = o_free ? q.ext : q.tel;
    assign o_send_sel = q.sel;
    assign o_par_err = q.err;
    assign o_pkw = (o_eff_telegram == `DSW_TEL_353) ||
        (o_eff_telegram == `DSW_TEL_354);
    assign o_tx_count = (o_eff_telegram == `DSW_TEL_STD1 ||
        o_eff_telegram == `DSW_TEL_353) ? `DSW_CNT_2 : `DSW_CNT_6;
endmodule

//--- logic/dsw_send_mux.sv
// Purpose: picks the actual value sent in each outgoing word
// Assumes: all sources are on the core clock
// Notes: combinational; the core registers the result
`include "dsw_defs.svh"
module dsw_send_mux (
    input dsw_pkg::dsw_word_t i_status,
    input dsw_pkg::dsw_word_t i_speed,
    input dsw_pkg::dsw_word_t i_current,
    input dsw_pkg::dsw_word_t i_torque,
    input dsw_pkg::dsw_word_t i_power,
    input dsw_pkg::dsw_word_t i_fault_code,
    input dsw_pkg::dsw_word_t i_warn_code,
    input dsw_pkg::dsw_sels_t i_sel,
    input wire i_free,
    input wire [2:0] i_count,
    output dsw_pkg::dsw_words_t o_words
);
    import dsw_pkg::*;

    genvar g;
    generate
        for (g = 0; g < `DSW_NWORDS; g = g + 1) begin : g_word
            dsw_sel_t src;
            dsw_word_t val;
            // outside free configuration the fixed map applies
            assign src = i_free ? i_sel[g*`DSW_SEL_W +: `DSW_SEL_W] :
                `DSW_SEL_W'(g);
            always_comb begin
                case (src)
                    3'h0: val = i_status;
                    3'h1: val = i_speed;
                    3'h2: val = i_current;
                    3'h3: val = i_torque;
                    3'h4: val = i_power;
                    3'h5: val = i_fault_code;
                    3'h6: val = i_warn_code;
                    default: val = '0;
                endcase
            end
            // words beyond the telegram's length send zero
            assign o_words[g*`DSW_WORD_W +: `DSW_WORD_W] =
                (3'(g) < i_count) ? val : '0;
        end
    endgenerate
endmodule

//--- logic/dsw_core.sv
// Purpose: drive state sequencing and the drive status word
// Assumes: control and process words arrive on the core clock
// Notes: status and send words refresh on each fieldbus cycle strobe
//
// Functional notes
// - bit0: supply and init done, pulses locked
// - bit1: ON active and no fault
// - enable operation in ready energizes motor
// - bit2: operation enabled, set only in the operation state
// - bit3: fault present, cleared by acknowledge
// - bit4 high when coast stop inactive
// - bit5 high when fast stop inactive
// - bit6: lockout, needs ON removed and reasserted
// - bit7: warning, motor keeps running, no ack
// - bit8: speed deviation inside tolerance band
// - bit9: request master control takeover
// - bit10: actual speed at or above comparison
// - bit11 low when limit reached
// - bit12: holding brake open outside telegram 20
// - bit14: sign of actual speed
// - bits 0-10 profile, 11-15 converter specific
// - telegram 20 keeps previous unassigned bit use
// - selected telegram map locked unless free
// - extended codes 1, 20, 352, 353, 354; the extension write also takes 999
// - receive words exposed on connector outputs
// - selection array chooses each send word
// - ack rising edge; ON still set gives lockout
`include "dsw_defs.svh"
module dsw_core (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_cycle_strobe,
    input dsw_pkg::dsw_word_t i_ctrl_word,
    input dsw_pkg::dsw_words_t i_rx_words,
    input wire i_supply_ok,
    input wire i_init_done,
    input wire i_fault,
    input wire i_warning,
    input wire i_master_req,
    input wire i_limit_reached,
    input wire i_motor_overtemp,
    input wire i_thermal_overload,
    input dsw_pkg::dsw_word_t i_speed_set,
    input dsw_pkg::dsw_word_t i_speed_act,
    input dsw_pkg::dsw_word_t i_speed_tol,
    input dsw_pkg::dsw_word_t i_speed_cmp,
    input dsw_pkg::dsw_word_t i_act_current,
    input dsw_pkg::dsw_word_t i_act_torque,
    input dsw_pkg::dsw_word_t i_act_power,
    input dsw_pkg::dsw_word_t i_fault_code,
    input dsw_pkg::dsw_word_t i_warn_code,
    input wire i_par_wr,
    input wire [1:0] i_par_id,
    input wire [`DSW_IDX_W-1:0] i_par_idx,
    input dsw_pkg::dsw_word_t i_par_data,
    output dsw_pkg::dsw_word_t o_drive_status_word,
    output logic o_pulse_enable,
    output logic o_fault_ack,
    output dsw_pkg::dsw_words_t o_rx_word_conn,
    output dsw_pkg::dsw_words_t o_tx_words,
    output dsw_pkg::dsw_word_t o_telegram,
    output logic o_pkw_enable,
    output logic [2:0] o_tx_count,
    output logic o_par_err
);
    import dsw_pkg::*;

    dsw_core_s q;
    dsw_core_s next_q;

    dsw_word_t eff_tel;
    logic free_cfg;
    logic [2:0] cnt;
    logic parameter_channel_words;
    dsw_sels_t send_sel;
    dsw_words_t tx_words;

    dsw_word_t cw_in;
    logic ack_edge;
    logic on_cmd;
    logic no_coast;
    logic no_fast;
    logic [16:0] dev;
    logic [16:0] dev_abs;
    logic in_tol;
    logic spd_ge;
    logic spd_gt0;
    logic spd_lt0;
    logic is_tel20;
    dsw_word_t sw;

    dsw_telegram_cfg u_cfg (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_par_wr(i_par_wr),
        .i_par_id(i_par_id),
        .i_par_idx(i_par_idx),
        .i_par_data(i_par_data),
        .o_eff_telegram(eff_tel),
        .o_free(free_cfg),
        .o_tx_count(cnt),
        .o_pkw(parameter_channel_words),
        .o_send_sel(send_sel),
        .o_par_err(o_par_err)
    );

    dsw_send_mux u_mux (
        .i_status(q.status),
        .i_speed(i_speed_act),
        .i_current(i_act_current),
        .i_torque(i_act_torque),
        .i_power(i_act_power),
        .i_fault_code(i_fault_code),
        .i_warn_code(i_warn_code),
        .i_sel(send_sel),
        .i_free(free_cfg),
        .i_count(q.tx_count),
        .o_words(tx_words)
    );

    // with control via the controller off, the last command is held
    always_comb begin
        cw_in = q.cw;
        if (i_cycle_strobe) begin
            if (i_ctrl_word[`DSW_CB_PLC_CTRL]) begin
                cw_in = i_ctrl_word;
            end else begin
                cw_in[`DSW_CB_PLC_CTRL] = 1'b0;
            end
        end
    end

    assign ack_edge = cw_in[`DSW_CB_FAULT_ACK] &
        ~q.cw[`DSW_CB_FAULT_ACK];
    assign on_cmd = q.cw[`DSW_CB_ON];
    assign no_coast = q.cw[`DSW_CB_NO_COAST];
    assign no_fast = q.cw[`DSW_CB_NO_FAST];

    // deviation is taken one bit wider so that it cannot wrap
    assign dev = {i_speed_set[`DSW_WORD_W-1], i_speed_set} -
        {i_speed_act[`DSW_WORD_W-1], i_speed_act};
    assign dev_abs = dev[16] ? 17'(~dev + 17'h00001) : dev;
    assign in_tol = dev_abs <= {1'b0, i_speed_tol};
    assign spd_ge = $signed(i_speed_act) >= $signed(i_speed_cmp);
    assign spd_lt0 = i_speed_act[`DSW_WORD_W-1];
    assign spd_gt0 = ~spd_lt0 & (|i_speed_act);
    assign is_tel20 = (q.tel == `DSW_TEL_STD20);

    // status word image; bits 0-10 profile, 11-15 converter use
    always_comb begin
        sw = `DSW_STATUS_RESET;
        sw[`DSW_SB_RDY_START] = (q.state == DSW_ST_RDY_START) ||
            (q.state == DSW_ST_READY) || (q.state == DSW_ST_OPER);
        sw[`DSW_SB_READY] = (q.state == DSW_ST_READY) ||
            (q.state == DSW_ST_OPER);
        sw[`DSW_SB_OPER] = (q.state == DSW_ST_OPER);
        sw[`DSW_SB_FAULT] = q.fault_lat;
        sw[`DSW_SB_NO_COAST] = no_coast;
        sw[`DSW_SB_NO_FAST] = no_fast;
        sw[`DSW_SB_LOCKOUT] = (q.state == DSW_ST_LOCKOUT);
        sw[`DSW_SB_WARN] = i_warning;
        sw[`DSW_SB_SPD_TOL] = in_tol;
        sw[`DSW_SB_MASTER_REQ] = i_master_req;
        sw[`DSW_SB_SPD_CMP] = spd_ge;
        sw[`DSW_SB_LIMIT_N] = ~i_limit_reached;
        // telegram 20 leaves bit 12 to whatever came before it
        sw[`DSW_SB_BRAKE] = (~is_tel20 | q.prev_valid) &
            (q.state == DSW_ST_OPER);
        sw[`DSW_SB_MOT_TEMP_N] = ~i_motor_overtemp;
        sw[`DSW_SB_CW] = spd_gt0 ? 1'b1 :
            (spd_lt0 ? 1'b0 : q.spd_pos);
        sw[`DSW_SB_B15] = is_tel20 ? q.cw[`DSW_CB_CDS0] :
            ~i_thermal_overload;
    end

    always_comb begin
        next_q = q;
        next_q.cw = cw_in;
        next_q.ack_pulse = ack_edge;
        // a new fault wins over a simultaneous acknowledge
        next_q.fault_lat = i_fault | (q.fault_lat & ~ack_edge);
        next_q.tel = eff_tel;
        next_q.parameter_channel_words = parameter_channel_words;
        next_q.tx_count = cnt;
        if (!is_tel20) begin
            next_q.prev_valid = 1'b1;
        end
        if (spd_gt0 | spd_lt0) begin
            next_q.spd_pos = spd_gt0;
        end
        if (i_cycle_strobe) begin
            next_q.status = sw;
            next_q.tx = tx_words;
            if (i_ctrl_word[`DSW_CB_PLC_CTRL]) begin
                next_q.rx = i_rx_words;
            end
        end
        case (q.state)
            DSW_ST_INIT: begin
                if (i_supply_ok && i_init_done) begin
                    next_q.state = DSW_ST_LOCKOUT;
                end
            end
            DSW_ST_LOCKOUT: begin
                // go to ready to start only with ON removed and both stops released
                if (!on_cmd && no_coast && no_fast) begin
                    next_q.state = DSW_ST_RDY_START;
                end
            end
            DSW_ST_RDY_START: begin
                if (on_cmd && !q.fault_lat) begin
                    next_q.state = DSW_ST_READY;
                end
            end
            DSW_ST_READY: begin
                if (!no_coast || !no_fast) begin
                    next_q.state = DSW_ST_LOCKOUT;
                end else if (!on_cmd) begin
                    next_q.state = DSW_ST_RDY_START;
                end else if (q.cw[`DSW_CB_ENABLE_OP]) begin
                    next_q.state = DSW_ST_OPER;
                end
            end
            DSW_ST_OPER: begin
                if (!no_coast || !no_fast) begin
                    next_q.state = DSW_ST_LOCKOUT;
                end else if (!on_cmd) begin
                    next_q.state = DSW_ST_RDY_START;
                end else if (!q.cw[`DSW_CB_ENABLE_OP]) begin
                    next_q.state = DSW_ST_READY;
                end
            end
            DSW_ST_FAULT: begin
                if (!q.fault_lat) begin
                    next_q.state = on_cmd ? DSW_ST_LOCKOUT :
                        DSW_ST_RDY_START;
                end
            end
            default: begin
                next_q.state = DSW_ST_INIT;
            end
        endcase
        // any fault after start-up drops the pulses at once
        if (q.fault_lat && q.state != DSW_ST_INIT) begin
            next_q.state = DSW_ST_FAULT;
        end
        if (!i_supply_ok) begin
            next_q.state = DSW_ST_INIT;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q.state <= DSW_ST_INIT;
            q.cw <= `DSW_CTRL_RESET;
            q.fault_lat <= 1'b0;
            q.ack_pulse <= 1'b0;
            q.spd_pos <= 1'b1;
            q.prev_valid <= 1'b0;
            q.status <= `DSW_STATUS_RESET;
            q.rx <= '0;
            q.tx <= '0;
            q.tel <= `DSW_TEL_STD1;
            q.parameter_channel_words <= 1'b0;
            q.tx_count <= `DSW_CNT_2;
        end else begin
            q <= next_q;
        end
    end

    assign o_drive_status_word = q.status;
    assign o_pulse_enable = (q.state == DSW_ST_OPER);
    assign o_fault_ack = q.ack_pulse;
    assign o_rx_word_conn = q.rx;
    assign o_tx_words = q.tx;
    assign o_telegram = q.tel;
    assign o_pkw_enable = q.parameter_channel_words;
    assign o_tx_count = q.tx_count;
endmodule

//--- sim/dsw_core_props.sv
// Purpose: port level checks of the drive status word core
// Assumes: one clock domain, asynchronous active low reset
// Notes: live flags are sampled at the strobe edge
`include "dsw_defs.svh"
module dsw_core_props (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_cycle_strobe,
    input dsw_pkg::dsw_word_t i_ctrl_word,
    input wire i_warning,
    input wire i_master_req,
    input wire i_limit_reached,
    input wire i_motor_overtemp,
    input dsw_pkg::dsw_word_t i_speed_act,
    input dsw_pkg::dsw_word_t i_speed_cmp,
    input wire i_par_wr,
    input wire [1:0] i_par_id,
    input dsw_pkg::dsw_word_t i_par_data,
    input dsw_pkg::dsw_word_t o_drive_status_word,
    input logic o_pulse_enable,
    input logic o_fault_ack,
    input dsw_pkg::dsw_word_t o_telegram,
    input logic o_pkw_enable,
    input logic [2:0] o_tx_count,
    input logic o_par_err
);
    import dsw_pkg::*;
    dsw_word_t held_cw;
    dsw_word_t sw;
    assign sw = o_drive_status_word;
    // the core shows the control word one strobe late, so keep our own copy
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            held_cw <= 16'h0000;
        end else if (i_cycle_strobe && i_ctrl_word[10]) begin
            held_cw <= i_ctrl_word;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    no_coast_bit_a: assert property (
        i_cycle_strobe |=> sw[4] == $past(held_cw[1]))
        else $error("status bit 4 does not follow coast stop bit");
    no_fast_bit_a: assert property (
        i_cycle_strobe |=> sw[5] == $past(held_cw[2]))
        else $error("status bit 5 does not follow fast stop bit");
    warn_bit_a: assert property (
        i_cycle_strobe |=> sw[7] == $past(i_warning))
        else $error("status bit 7 does not follow warning");
    live_flags_a: assert property (i_cycle_strobe |=>
        sw[9] == $past(i_master_req) && sw[11] == !$past(i_limit_reached)
        && sw[13] == !$past(i_motor_overtemp))
        else $error("status bits 9, 11 or 13 wrong");
    speed_cmp_a: assert property (i_cycle_strobe |=>
        sw[10] == ($signed($past(i_speed_act)) >= $signed($past(i_speed_cmp))))
        else $error("status bit 10 wrong");
    status_hold_a: assert property (
        !i_cycle_strobe |=> $stable(o_drive_status_word))
        else $error("status word changed without a strobe");
    ready_clean_a: assert property (
        sw[1] |-> sw[0] && !sw[6])
        else $error("ready shown with lockout or without ready to start");
    oper_ready_a: assert property (sw[2] |-> sw[1])
        else $error("operation enabled shown without ready");
    ack_pulse_a: assert property (o_fault_ack |=> !o_fault_ack)
        else $error("fault acknowledge pulse longer than one cycle");
    par_refuse_a: assert property (
        i_par_wr && i_par_id == 2'h3 |=> o_par_err)
        else $error("write to unknown parameter not refused");
    tel_fixed_a: assert property (
        i_par_wr && i_par_id == 2'h0 && i_par_data == 16'h0001 ##1 !i_par_wr
        |=> o_telegram == 16'h0001 && o_tx_count == 3'h2 && !o_pkw_enable)
        else $error("fixed telegram write not applied");
    pkw_code_a: assert property (
        o_pkw_enable |-> o_telegram == 16'h0161 || o_telegram == 16'h0162)
        else $error("parameter words enabled for wrong telegram");
    count_code_a: assert property (o_tx_count ==
        ((o_telegram == 16'h0001 || o_telegram == 16'h0161) ? 3'h2 : 3'h6))
        else $error("send word count does not match telegram");
    cover property (o_fault_ack);
    cover property ($rose(o_pulse_enable));
    cover property (o_telegram == 16'h0014 && o_tx_count == 3'h6);
endmodule

bind dsw_core dsw_core_props i_dsw_core_props (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_cycle_strobe(i_cycle_strobe), .i_ctrl_word(i_ctrl_word),
    .i_warning(i_warning), .i_master_req(i_master_req),
    .i_limit_reached(i_limit_reached), .i_motor_overtemp(i_motor_overtemp),
    .i_speed_act(i_speed_act), .i_speed_cmp(i_speed_cmp),
    .i_par_wr(i_par_wr), .i_par_id(i_par_id), .i_par_data(i_par_data),
    .o_drive_status_word(o_drive_status_word),
    .o_pulse_enable(o_pulse_enable), .o_fault_ack(o_fault_ack),
    .o_telegram(o_telegram), .o_pkw_enable(o_pkw_enable),
    .o_tx_count(o_tx_count), .o_par_err(o_par_err)
);

//--- sim/dsw_plc_model.sv
// Purpose: fieldbus controller issuing cyclic control and receive words
// Assumes: driven on falling edges of the core clock
// Notes: receive words are only valid in the strobe cycle
module dsw_plc_model (
    input wire i_core_clk,
    output logic o_cycle_strobe,
    output dsw_pkg::dsw_word_t o_ctrl_word,
    output dsw_pkg::dsw_words_t o_rx_words
);
    timeunit 1ns;
    timeprecision 1ps;
    import dsw_pkg::*;
    dsw_words_t sent_rx;
    dsw_words_t pattern;
    initial begin
        o_cycle_strobe = 1'b0;
        o_ctrl_word = 16'h0000;
        pattern = 96'h0605_0504_0403_0302_0201_0100;
        o_rx_words = ~pattern;
        sent_rx = pattern;
    end
    task automatic cycles(input dsw_word_t cw, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge i_core_clk);
            pattern = pattern + {6{16'h0101}};
            o_cycle_strobe = 1'b1;
            o_ctrl_word = cw;
            o_rx_words = pattern;
            sent_rx = pattern;
            @(negedge i_core_clk);
            o_cycle_strobe = 1'b0;
            // stale words must not look valid between cycles
            o_rx_words = ~pattern;
            repeat (2) @(negedge i_core_clk);
        end
    endtask
endmodule

//--- sim/dsw_core_tb.sv
// Purpose: self-checking bench of the drive status word core
// Assumes: the controller model issues all fieldbus cycles
// Notes: three strobes per step let the state chain settle
`include "dsw_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module dsw_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsw_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_cycle_strobe;
    dsw_word_t i_ctrl_word;
    dsw_words_t i_rx_words;
    logic i_supply_ok, i_init_done, i_fault, i_warning, i_master_req;
    logic i_limit_reached, i_motor_overtemp, i_thermal_overload;
    dsw_word_t i_speed_set, i_speed_act, i_speed_tol, i_speed_cmp;
    dsw_word_t i_act_current, i_act_torque, i_act_power;
    dsw_word_t i_fault_code, i_warn_code, i_par_data;
    logic i_par_wr;
    logic [1:0] i_par_id;
    logic [2:0] i_par_idx;
    dsw_word_t o_drive_status_word, o_telegram;
    dsw_words_t o_rx_word_conn, o_tx_words;
    logic o_pulse_enable, o_fault_ack, o_pkw_enable, o_par_err;
    logic [2:0] o_tx_count;
    int errors = 0;
    int n_tests = 0;
    int acks = 0;
    dsw_word_t codes [5] = '{16'h0001, 16'h0014, 16'h0160, 16'h0161, 16'h0162};
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (o_fault_ack === 1'b1) acks++;
    dsw_plc_model i_dsw_plc_model (.i_core_clk(i_core_clk),
        .o_cycle_strobe(i_cycle_strobe), .o_ctrl_word(i_ctrl_word),
        .o_rx_words(i_rx_words));
    dsw_core i_dsw_core (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_cycle_strobe(i_cycle_strobe), .i_ctrl_word(i_ctrl_word),
        .i_rx_words(i_rx_words), .i_supply_ok(i_supply_ok),
        .i_init_done(i_init_done), .i_fault(i_fault), .i_warning(i_warning),
        .i_master_req(i_master_req), .i_limit_reached(i_limit_reached),
        .i_motor_overtemp(i_motor_overtemp),
        .i_thermal_overload(i_thermal_overload), .i_speed_set(i_speed_set),
        .i_speed_act(i_speed_act), .i_speed_tol(i_speed_tol),
        .i_speed_cmp(i_speed_cmp), .i_act_current(i_act_current),
        .i_act_torque(i_act_torque), .i_act_power(i_act_power),
        .i_fault_code(i_fault_code), .i_warn_code(i_warn_code),
        .i_par_wr(i_par_wr), .i_par_id(i_par_id), .i_par_idx(i_par_idx),
        .i_par_data(i_par_data), .o_drive_status_word(o_drive_status_word),
        .o_pulse_enable(o_pulse_enable), .o_fault_ack(o_fault_ack),
        .o_rx_word_conn(o_rx_word_conn), .o_tx_words(o_tx_words),
        .o_telegram(o_telegram), .o_pkw_enable(o_pkw_enable),
        .o_tx_count(o_tx_count), .o_par_err(o_par_err));
    task automatic results();
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic step(input dsw_word_t cw, input dsw_word_t exp);
        i_dsw_plc_model.cycles(cw, 3);
        `CHK(o_drive_status_word, exp)
        `CHK(o_rx_word_conn, i_dsw_plc_model.sent_rx)
    endtask
    task automatic par(input logic [1:0] id, input logic [2:0] idx,
        input dsw_word_t data, input logic err);
        @(negedge i_core_clk);
        i_par_wr = 1'b1;
        i_par_id = id;
        i_par_idx = idx;
        i_par_data = data;
        @(negedge i_core_clk);
        i_par_wr = 1'b0;
        `CHK(o_par_err, err)
        @(negedge i_core_clk);
    endtask
    initial begin
        #(100000 * 40);
        errors++;
        results();
    end
    initial begin
        {i_fault, i_warning, i_master_req, i_limit_reached} = 4'h0;
        {i_motor_overtemp, i_thermal_overload, i_par_wr} = 3'h0;
        {i_supply_ok, i_init_done} = 2'h3;
        {i_speed_set, i_speed_act, i_speed_tol} = {16'h0064, 16'h0064, 16'h0};
        i_speed_cmp = 16'h00c8;
        {i_act_current, i_act_torque, i_act_power} = 48'h0c0c_0d0d_0e0e;
        {i_fault_code, i_warn_code} = 32'h0f0f_0a0a;
        {i_par_id, i_par_idx, i_par_data} = 21'h0;
        repeat (6) @(negedge i_core_clk);
        `CHK(o_drive_status_word, `DSW_STATUS_RESET)
        `CHK(o_telegram, `DSW_TEL_STD1)
        i_rstn = 1'b1;
        step(16'h0406, 16'he931);
        step(16'h0407, 16'he933);
        step(16'h040f, 16'hf937);
        `CHK(o_pulse_enable, 1'b1)
        i_warning = 1'b1;
        step(16'h040f, 16'hf9b7);
        i_warning = 1'b0;
        i_fault = 1'b1;
        step(16'h040f, 16'he938);
        `CHK(o_pulse_enable, 1'b0)
        i_fault = 1'b0;
        step(16'h040f, 16'he938);
        step(16'h048f, 16'he970);
        `CHK(acks, 1)
        step(16'h048f, 16'he970);
        step(16'h040e, 16'he931);
        step(16'h040f, 16'hf937);
        step(16'h040d, 16'he960);
        step(16'h040b, 16'he950);
        {i_master_req, i_limit_reached} = 2'h3;
        {i_motor_overtemp, i_thermal_overload} = 2'h3;
        i_speed_act = 16'hff9c;
        step(16'h0406, 16'h0231);
        {i_master_req, i_limit_reached, i_motor_overtemp} = 3'h0;
        {i_speed_act, i_speed_tol, i_speed_cmp} = {3{16'h00c8}};
        step(16'h0406, 16'h6d31);
        par(2'h0, 3'h0, 16'h0309, 1'b1);
        par(2'h1, 3'h0, 16'h0014, 1'b1);
        par(2'h3, 3'h0, 16'h0000, 1'b1);
        par(2'h0, 3'h0, `DSW_TEL_FREE, 1'b0);
        par(2'h2, 3'h6, 16'h0001, 1'b1);
        for (int k = 0; k < 5; k++) begin
            par(2'h1, 3'h0, codes[k], 1'b0);
            `CHK(o_telegram, codes[k])
            `CHK(o_tx_count, (k == 0 || k == 3) ? 3'h2 : 3'h6)
            `CHK(o_pkw_enable, k > 2)
        end
        par(2'h2, 3'h0, 16'h0001, 1'b0);
        step(16'h0406, 16'h6d31);
        `CHK(o_tx_words[15:0], i_speed_act)
        `CHK(o_tx_words[95:16], {i_fault_code, i_act_power, i_act_torque,
            i_act_current, i_speed_act})
        par(2'h1, 3'h0, `DSW_TEL_STD20, 1'b0);
        step(16'h8406, 16'hed31);
        par(2'h0, 3'h0, `DSW_TEL_STD1, 1'b0);
        step(16'h0406, 16'h6d31);
        `CHK(o_tx_words[95:32], 64'h0)
        `CHK(o_tx_words[31:16], i_speed_act)
        results();
    end
endmodule
